// >>> verilog/mlbm_pkg.sv
// Package for the multi-layer bus matrix: indices, map, access table, carriers
package mlbm_pkg;
    localparam int NUM_MASTERS = 5;
    localparam int NUM_SLAVES  = 10;
    localparam int MIDX_W      = 3;
    localparam int SIDX_W      = 4;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 32;

    localparam logic [MIDX_W-1:0] M_CORE_ID  = 3'h0;
    localparam logic [MIDX_W-1:0] M_CORE_SYS = 3'h1;
    localparam logic [MIDX_W-1:0] M_PER_DMA  = 3'h2;
    localparam logic [MIDX_W-1:0] M_USB_DMA  = 3'h3;
    localparam logic [MIDX_W-1:0] M_GEN_DMA  = 3'h4;

    localparam logic [SIDX_W-1:0] S_SRAM_BANK_ZERO = 4'h0;
    localparam logic [SIDX_W-1:0] S_SRAM_BANK_ONE  = 4'h1;
    localparam logic [SIDX_W-1:0] S_ROM            = 4'h2;
    localparam logic [SIDX_W-1:0] S_FLASH0         = 4'h3;
    localparam logic [SIDX_W-1:0] S_FLASH1         = 4'h4;
    localparam logic [SIDX_W-1:0] S_USB_DUAL_PORT_RAM = 4'h5;
    localparam logic [SIDX_W-1:0] S_NAND_RAM       = 4'h6;
    localparam logic [SIDX_W-1:0] S_EXT_BUS        = 4'h7;
    localparam logic [SIDX_W-1:0] S_LS_BRIDGE      = 4'h8;
    localparam logic [SIDX_W-1:0] S_HS_BRIDGE      = 4'h9;
    localparam logic [SIDX_W-1:0] S_NONE           = 4'hF;

    // Region base and mask per slave (hit when (addr & mask) == base)
    localparam logic [ADDR_W-1:0] BASE [NUM_SLAVES] = '{
        32'h2000_0000, 32'h2008_0000, 32'h0018_0000, 32'h0008_0000,
        32'h0010_0000, 32'h2000_0000 | 32'h0060_0000, 32'h2010_0000,
        32'h6000_0000, 32'h400E_0000, 32'h4000_0000};
    localparam logic [ADDR_W-1:0] MASK [NUM_SLAVES] = '{
        32'hFFF8_0000, 32'hFFF8_0000, 32'hFFF8_0000, 32'hFFF8_0000,
        32'hFFF8_0000, 32'hFFF8_0000, 32'hFFF8_0000,
        32'hF000_0000, 32'hFFFE_0000, 32'hFFFE_0000};

    // Wired paths: bit m of entry s set when master m reaches slave s
    localparam logic [NUM_MASTERS-1:0] WIRED [NUM_SLAVES] = '{
        5'h1E, 5'h1E, 5'h1D, 5'h01, 5'h01,
        5'h02, 5'h1E, 5'h1E, 5'h06, 5'h06};

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mlbm_req_s;

    typedef struct packed {
        logic              done;
        logic              error;
        logic [DATA_W-1:0] rdata;
    } mlbm_rsp_s;
endpackage

// >>> verilog/mlbm_arbiter.sv
// Per-slave round-robin arbiter holding its grant until the transfer ends
`timescale 1ns/1ps
`default_nettype none
module mlbm_arbiter #(
    parameter int N = 5
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] req,
    input  wire logic         xfer_done,
    output logic      [N-1:0] grant,
    output logic              busy
);
    logic [N-1:0] grant_ff;
    logic [N-1:0] last_ff;
    logic [N-1:0] nxt_grant;

    // One-cycle search: wider rings would stretch the combinational path
    if (N < 2 || N > 8) begin : g_bad_n
        $error("mlbm_arbiter: N out of range");
    end

    // Search starts one past the last winner so no master starves
    always_comb begin
        logic [2*N-1:0] dbl;
        logic [N-1:0]   pick;
        dbl  = {req, req};
        pick = '0;
        for (int k = 1; k <= N; k++) begin
            for (int i = 0; i < N; i++) begin
                if (last_ff[i] && dbl[i+k] && pick == '0) begin
                    pick = N'(1) << ((i + k) % N);
                end
            end
        end
        nxt_grant = (req != '0) ? pick : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            grant_ff <= '0;
            last_ff  <= N'(1) << (N - 1);
        end else if (grant_ff == '0 || xfer_done) begin
            grant_ff <= xfer_done ? '0 : nxt_grant;
            if (!xfer_done && nxt_grant != '0) last_ff <= nxt_grant;
        end
    end

    assign grant = grant_ff;
    assign busy  = grant_ff != '0;
endmodule
`default_nettype wire

// >>> verilog/mlbm_matrix.sv
// Multi-layer bus matrix top: per-master decode, per-slave arbitration
//
// Functional notes
// - Five masters may each complete transfers concurrently to different slaves.
// - Each master has its own decoder and its own request path.
// - All decoders share one address map.
// - Ten slaves, each with a separate arbiter.
// - Masters: core I/D, core system, peripheral DMA, USB DMA, general DMA.
// - Slaves: SRAMs, ROM, flashes, USB RAM, NAND RAM, ext bus, bridges.
// - Low and high speed bridges are distinct slaves, usable concurrently.
// - High speed bridge hosts only serial interface, serial ctrl, card host.
// - Peripherals with peripheral DMA channels are not served by general DMA.
// - High speed bridge peripherals move data through peripheral DMA.
// - Both bridges run on the single master clock.
// - Meaningless master to slave paths are not wired.
`timescale 1ns/1ps
`default_nettype none
module mlbm_matrix
    import mlbm_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire mlbm_pkg::mlbm_req_s m_req   [mlbm_pkg::NUM_MASTERS],
    output mlbm_pkg::mlbm_rsp_s      m_rsp   [mlbm_pkg::NUM_MASTERS],
    output mlbm_pkg::mlbm_req_s      s_req   [mlbm_pkg::NUM_SLAVES],
    output logic [mlbm_pkg::MIDX_W-1:0] s_master [mlbm_pkg::NUM_SLAVES],
    input  wire mlbm_pkg::mlbm_rsp_s s_rsp   [mlbm_pkg::NUM_SLAVES]
);
    import mlbm_pkg::*;

    logic [SIDX_W-1:0]      dec_slave [NUM_MASTERS];
    logic [NUM_MASTERS-1:0] hit_ok;
    logic [NUM_MASTERS-1:0] err_pulse;
    logic [NUM_SLAVES-1:0]  region_hit [NUM_MASTERS];
    logic [NUM_MASTERS-1:0] req_v [NUM_SLAVES];
    logic [NUM_MASTERS-1:0] gnt   [NUM_SLAVES];

    // Error responder per master: answers one cycle after an unmapped request
    typedef enum logic [0:0] {
        ERR_IDLE   = 1'b0,
        ERR_ANSWER = 1'b1
    } mlbm_err_e;
    mlbm_err_e              err_state_ff [NUM_MASTERS];

    // One decoder per master, all from the same table
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_dec
        // One comparator per region; the map keeps regions disjoint
        for (genvar r = 0; r < NUM_SLAVES; r++) begin : g_cmp
            assign region_hit[m][r] =
                (m_req[m].addr & MASK[r]) == BASE[r];
        end

        // Lowest index wins should a future map ever overlap
        always_comb begin
            dec_slave[m] = S_NONE;
            for (int s = NUM_SLAVES - 1; s >= 0; s--) begin
                if (region_hit[m][s]) begin
                    dec_slave[m] = SIDX_W'(s);
                end
            end
        end

        // Unwired path treated as unmapped so the master is answered
        assign hit_ok[m] = (dec_slave[m] != S_NONE) &&
                           WIRED[dec_slave[m]][m];

        // Error answered one cycle later as a one-cycle done pulse;
        // a master that keeps valid up sees it every other cycle
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                err_state_ff[m] <= ERR_IDLE;
            end else begin
                unique case (err_state_ff[m])
                    ERR_IDLE: begin
                        if (m_req[m].valid && !hit_ok[m]) begin
                            err_state_ff[m] <= ERR_ANSWER;
                        end
                    end
                    ERR_ANSWER: begin
                        err_state_ff[m] <= ERR_IDLE;
                    end
                endcase
            end
        end
        assign err_pulse[m] = err_state_ff[m] == ERR_ANSWER;
    end

    // One arbiter per slave, fed only by wired masters
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
        for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_rq
            assign req_v[s][m] = m_req[m].valid && hit_ok[m] &&
                                 dec_slave[m] == SIDX_W'(s);
        end

        mlbm_arbiter #(.N(NUM_MASTERS)) u_arb (
            .ref_clk   (ref_clk),
            .rst       (rst),
            .req       (req_v[s]),
            .xfer_done (s_rsp[s].done),
            .grant     (gnt[s]),
            .busy      ()
        );

        always_comb begin
            s_req[s]    = '0;
            s_master[s] = '0;
            for (int m = 0; m < NUM_MASTERS; m++) begin
                if (gnt[s][m]) begin
                    s_req[s]    = m_req[m];
                    s_req[s].valid = m_req[m].valid;
                    s_master[s] = MIDX_W'(m);
                end
            end
        end
    end

    // Response routing: each master sees only the slave granting it
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_rsp
        always_comb begin
            m_rsp[m] = '0;
            for (int s = 0; s < NUM_SLAVES; s++) begin
                if (gnt[s][m]) begin
                    m_rsp[m] = s_rsp[s];
                end
            end
            if (err_pulse[m]) begin
                m_rsp[m].done  = 1'b1;
                m_rsp[m].error = 1'b1;
            end
        end
    end
    // Elaboration checks: a broken table would misroute without a trace
    if (NUM_MASTERS > (1 << MIDX_W)) begin : g_bad_midx
        $error("mlbm_matrix: master index field too narrow");
    end

    if (NUM_SLAVES > (1 << SIDX_W) - 1) begin : g_bad_sidx
        $error("mlbm_matrix: no spare slave code for unmapped");
    end

    // Distinct bridge slaves, each with its own arbiter, run at once;
    // all logic is on ref_clk, the master clock, so no crossing exists.
    if (S_LS_BRIDGE == S_HS_BRIDGE) begin : g_one_bridge
        $error("mlbm_matrix: bridges must be separate slaves");
    end

    // Channel owners sit behind the low speed bridge, out of general DMA
    if (WIRED[S_LS_BRIDGE][M_GEN_DMA]) begin : g_dma_ls
        $error("mlbm_matrix: general DMA wired to low speed bridge");
    end

    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_map_chk
        if ((BASE[s] & ~MASK[s]) != '0) begin : g_unaligned
            $error("mlbm_matrix: region base not aligned to its mask");
        end
        if (WIRED[s] == '0) begin : g_unreached
            $error("mlbm_matrix: slave wired to no master");
        end
        // Instruction port only fetches from ROM and flash
        if (WIRED[s][M_CORE_ID] && s != S_ROM &&
            s != S_FLASH0 && s != S_FLASH1) begin : g_core_id
            $error("mlbm_matrix: instruction port wired past code");
        end
        if (WIRED[s][M_USB_DMA] &&
            (s == S_LS_BRIDGE || s == S_HS_BRIDGE)) begin : g_usb_br
            $error("mlbm_matrix: USB DMA wired to a bridge");
        end
        for (genvar t = s + 1; t < NUM_SLAVES; t++) begin : g_pair
            if (((BASE[s] ^ BASE[t]) & MASK[s] & MASK[t]) == '0) begin : g_ovl
                $error("mlbm_matrix: two regions overlap");
            end
        end
    end

    // Which peripheral sits behind which bridge, and which DMA moves its
    // data, is settled behind the bridges; the matrix keeps the paths.
    // Index assignment follows the package constants.
endmodule
`default_nettype wire

// >>> test/mlbm_matrix_props.sv
// Checker for the bus matrix top ports
`timescale 1ns/1ps
`default_nettype none
module mlbm_matrix_props
    import mlbm_pkg::*;
(
    input wire logic                         ref_clk,
    input wire logic                         rst,
    input wire mlbm_pkg::mlbm_req_s          m_req [mlbm_pkg::NUM_MASTERS],
    input wire mlbm_pkg::mlbm_rsp_s          m_rsp [mlbm_pkg::NUM_MASTERS],
    input wire mlbm_pkg::mlbm_req_s          s_req [mlbm_pkg::NUM_SLAVES],
    input wire logic [mlbm_pkg::MIDX_W-1:0]  s_master [mlbm_pkg::NUM_SLAVES],
    input wire mlbm_pkg::mlbm_rsp_s          s_rsp [mlbm_pkg::NUM_SLAVES]
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_err_pulse;
        m_rsp[0].done && m_rsp[0].error ##1 !m_rsp[0].done;
    endsequence
    sequence s_core_sram;
        $rose(m_req[0].valid) && m_req[0].addr[31:20] == 12'h200;
    endsequence
    property p_err; s_core_sram |-> ##[1:2] s_err_pulse; endproperty
    a_err: assert property (p_err) else $error("no bus error");
    property p_hold;
        s_req[0].valid && !s_rsp[0].done |=> s_req[0].valid && $stable(s_master[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("grant dropped");
    property p_flash; s_req[3].valid |-> s_master[3] == M_CORE_ID; endproperty
    a_flash: assert property (p_flash) else $error("bad flash path");
    property p_bridge; s_req[8].valid |-> s_master[8] inside {3'h1, 3'h2}; endproperty
    a_bridge: assert property (p_bridge) else $error("bad bridge path");
    property p_map; s_req[2].valid |-> s_req[2].addr[31:19] == 13'h3; endproperty
    a_map: assert property (p_map) else $error("bad decode");
    property p_path; s_rsp[7].done && s_req[7].valid |-> m_rsp[s_master[7]].done;
    endproperty
    a_path: assert property (p_path) else $error("done lost");
    property p_grant;
        $rose(m_req[1].valid) && m_req[1].addr[31:19] == 13'h40C
            |-> ##[1:2] s_req[5].valid && s_master[5] == M_CORE_SYS;
    endproperty
    a_grant: assert property (p_grant) else $error("no grant");
    property p_pulse; m_rsp[2].done |=> !m_rsp[2].done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
endmodule
bind mlbm_matrix mlbm_matrix_props mlbm_matrix_props_i (.ref_clk(ref_clk),
    .rst(rst), .m_req(m_req), .m_rsp(m_rsp), .s_req(s_req),
    .s_master(s_master), .s_rsp(s_rsp));
`default_nettype wire

// >>> test/mlbm_slave_model.sv
// Slave responders with random wait states
`timescale 1ns/1ps
`default_nettype none
module mlbm_slave_model
    import mlbm_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire mlbm_pkg::mlbm_req_s s_req [mlbm_pkg::NUM_SLAVES],
    output var mlbm_pkg::mlbm_rsp_s s_rsp [mlbm_pkg::NUM_SLAVES]
);
    logic [1:0] wait_ff [NUM_SLAVES];
    // Idle read data is noise so stale values never match
    always @(posedge ref_clk) begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            if (!rst && s_req[s].valid && !s_rsp[s].done && wait_ff[s] == 0)
                s_rsp[s] <= '{1'b1, 1'b0, ~s_req[s].addr};
            else
                s_rsp[s] <= '{1'b0, 1'b0, 32'($urandom)};
            if (rst || !s_req[s].valid || s_rsp[s].done)
                wait_ff[s] <= 2'($urandom);
            else if (wait_ff[s] != 0)
                wait_ff[s] <= wait_ff[s] - 2'h1;
        end
    end
endmodule
`default_nettype wire

// >>> test/mlbm_matrix_bench.sv
// Bench: five masters issue random concurrent transfers
`timescale 1ns/1ps
`default_nettype none
module mlbm_matrix_bench;
    import mlbm_pkg::*;
    logic      ref_clk = 0;
    logic      rst = 1;
    mlbm_req_s m_req [NUM_MASTERS] = '{default: '0};
    mlbm_rsp_s m_rsp [NUM_MASTERS];
    mlbm_req_s s_req [NUM_SLAVES];
    logic [MIDX_W-1:0] s_master [NUM_SLAVES];
    mlbm_rsp_s s_rsp [NUM_SLAVES];
    int num_errors = 0;
    int tests_run = 0;
    mlbm_matrix mlbm_matrix_i (.ref_clk(ref_clk), .rst(rst), .m_req(m_req),
        .m_rsp(m_rsp), .s_req(s_req), .s_master(s_master), .s_rsp(s_rsp));
    mlbm_slave_model mlbm_slave_model_i (.ref_clk(ref_clk), .rst(rst),
        .s_req(s_req), .s_rsp(s_rsp));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Slot 10 is an unmapped address; unwired pairs must also error
    task automatic xfer(input int m, input int k);
        logic [31:0] a;
        logic [31:0] d;
        logic        w;
        logic        e;
        int          n;
        a = (k == 10) ? 32'h3000_0000 : BASE[k] | (32'($urandom) & 32'hFFC);
        d = $urandom;
        w = 1'($urandom);
        e = (k == 10) || !WIRED[k][m];
        @(posedge ref_clk);
        m_req[m] <= '{1'b1, w, a, d};
        n = 0;
        do begin @(posedge ref_clk); n++; end
        while (m_rsp[m].done !== 1'b1 && n < 300);
        // Grant still stands at the edge that shows done
        check({31'h0, m_rsp[m].done}, 32'h1);
        check({31'h0, m_rsp[m].error}, {31'h0, e});
        if (!e) begin
            check({29'h0, s_master[k]}, 32'(m));
            check(s_req[k].addr, a);
            check({31'h0, s_req[k].write}, {31'h0, w});
            if (w) check(s_req[k].wdata, d);
            else check(m_rsp[m].rdata, ~a);
        end
        m_req[m] <= '0;
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // About 61 transfers a master, five sharing one slave at eight cycles
    // each, stays far below this 50,000 cycle limit
    initial begin
        #500_000;
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(32'h3FA3));
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        xfer(0, 0);
        xfer(1, 5);
        for (int i = 0; i < NUM_MASTERS; i++) begin
            fork
                automatic int j = i;
                repeat (60) xfer(j, $urandom % 11);
            join_none
        end
        wait fork;
        summarize();
    end
endmodule
`default_nettype wire
